// ### logic/rpb_framer.sv
`timescale 1ns/100ps
`default_nettype none
module rpb_framer (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [9:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output var  logic [7:0] o_reg_rdata,
  // radio commands
  input  wire logic       i_transmit_command,
  input  wire logic       i_receive_command,
  input  wire logic       i_stop_command,
  // transmit frame store write
  input  wire logic       i_txs_wr,
  input  wire logic [4:0] i_txs_addr,
  input  wire logic [7:0] i_txs_wdata,
  // receive frame store read
  input  wire logic [4:0] i_rxs_addr,
  output var  logic [7:0] o_rxs_data,
  // air transmit side
  output var  logic       o_air_tx_valid,
  output var  logic [7:0] o_air_tx_data,
  input  wire logic       i_air_tx_ready,
  output var  logic       o_pa_on,
  // air receive side
  input  wire logic       i_air_rx_valid,
  input  wire logic [7:0] i_air_rx_data,
  input  wire logic [7:0] i_rssi,
  input  wire logic [7:0] i_sqi,
  output var  logic       o_sfd_search,
  // status
  output var  logic       o_radio_idle_state,
  output var  logic       o_frame_rcvd,
  output var  logic       o_addon_enable
);
  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [7:0] bufcfg_ff;
  logic [7:0] pktcfg_ff;
  logic [7:0] rxdly_ff;
  logic [7:0] txdly_ff;
  logic [7:0] dlyext_ff;
  logic       crc_ok_ff;
  wire wr_bufcfg = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_BUFCFG);
  wire wr_pktcfg = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_PKTCFG);
  wire wr_rxdly  = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_RXDLY);
  wire wr_txdly  = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_TXDLY);
  wire wr_dlyext = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_DLYEXT);
  wire wr_status = i_reg_wr && (i_reg_addr == rpb_pkg::ADDR_STATUS);
  wire       macdly_off  = bufcfg_ff[rpb_pkg::BIT_MACDLY_OFF];
  wire [1:0] tx_mode     = bufcfg_ff[rpb_pkg::TXMODE_LO +: 2];
  wire       send_listen = bufcfg_ff[rpb_pkg::BIT_SEND_LISTEN];
  wire       listen_send = bufcfg_ff[rpb_pkg::BIT_LISTEN_SEND];
  wire [1:0] rx_mode     = bufcfg_ff[rpb_pkg::RXMODE_LO +: 2];
  wire       skip_settle = pktcfg_ff[rpb_pkg::BIT_SKIP_SETTLE];
  wire       fcs_on      = !pktcfg_ff[rpb_pkg::BIT_FCS_OFF];
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bufcfg_ff <= rpb_pkg::RST_BUFCFG;
      pktcfg_ff <= rpb_pkg::RST_PKTCFG;
      rxdly_ff  <= rpb_pkg::RST_RXDLY;
      txdly_ff  <= rpb_pkg::RST_TXDLY;
      dlyext_ff <= rpb_pkg::RST_DLYEXT;
    end
    else
    begin
      if (wr_bufcfg) bufcfg_ff <= i_reg_wdata;
      if (wr_pktcfg) pktcfg_ff <= i_reg_wdata;
      if (wr_rxdly)  rxdly_ff  <= i_reg_wdata;
      if (wr_txdly)  txdly_ff  <= i_reg_wdata;
      if (wr_dlyext) dlyext_ff <= i_reg_wdata;
    end
  end
  // ------------------------------------------------------------
  // delay timer, one tick per microsecond
  // ------------------------------------------------------------
  rpb_pkg::rpb_state_t state_ff;
  rpb_pkg::rpb_state_t nxt_state;
  logic [10:0] cnt_ff;
  logic [7:0]  div_ff;
  logic        load;
  logic [10:0] load_val;
  wire  [10:0] ext_us = 11'(dlyext_ff) * 11'(rpb_pkg::EXT_STEP_US);
  wire  [10:0] tx_wait_us = macdly_off ? 11'h000 :
                            11'(txdly_ff) + ext_us;
  wire  [10:0] rx_wait_us = macdly_off ? 11'h000 :
                            11'(rxdly_ff) + ext_us;
  wire         tick = (div_ff == 8'(rpb_pkg::TICK_CYC - 1));
  wire         cnt_zero = (cnt_ff == 11'h000);
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff <= 11'h000;
      div_ff <= 8'h00;
    end
    else if (load)
    begin
      cnt_ff <= load_val;
      div_ff <= 8'h00;
    end
    else
    begin
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
      if (tick && !cnt_zero) cnt_ff <= cnt_ff - 11'h001;
    end
  end
  // ------------------------------------------------------------
  // transmit datapath
  // ------------------------------------------------------------
  logic [7:0]  txs_mem [rpb_pkg::STORE_DEPTH];
  logic [7:0]  rxs_mem [rpb_pkg::STORE_DEPTH];
  logic [4:0]  tx_idx_ff;
  logic [15:0] crc;
  rpb_stream_if #(.W(8)) tx_in ();
  rpb_stream_if #(.W(8)) tx_out ();
  wire [4:0] tx_len   = txs_mem[0][4:0];
  wire       tx_fcs_lo = fcs_on && (tx_idx_ff == tx_len - 5'h01);
  wire       tx_fcs_hi = fcs_on && (tx_idx_ff == tx_len);
  wire [7:0] tx_byte  = tx_fcs_lo ? crc[7:0] :
                        tx_fcs_hi ? crc[15:8] :
                        txs_mem[tx_idx_ff];
  wire       push      = tx_in.valid && tx_in.ready;
  wire       push_last = push && (tx_idx_ff == tx_len);
  wire       tx_crc_en = push && (tx_idx_ff != 5'h00) &&
                         !tx_fcs_lo && !tx_fcs_hi;
  wire       drained   = !tx_out.valid && !o_air_tx_valid;
  assign tx_in.valid  = (state_ff == rpb_pkg::ST_TX_SEND);
  assign tx_in.data   = tx_byte;
  assign tx_out.ready = !o_air_tx_valid || i_air_tx_ready;
  rpb_fifo #(
    .W (8),
    .D (16)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .s_in       (tx_in),
    .s_out      (tx_out)
  );
  always_ff @(posedge i_core_clk)
  begin
    if (i_txs_wr) txs_mem[i_txs_addr] <= i_txs_wdata;
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)                               tx_idx_ff <= 5'h00;
    else if (state_ff != rpb_pkg::ST_TX_SEND) tx_idx_ff <= 5'h00;
    else if (push)                           tx_idx_ff <= tx_idx_ff + 5'h01;
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_air_tx_valid <= 1'b0;
      o_air_tx_data  <= 8'h00;
    end
    else if (tx_out.ready)
    begin
      o_air_tx_valid <= tx_out.valid;
      o_air_tx_data  <= tx_out.data;
    end
  end
  // ------------------------------------------------------------
  // receive datapath
  // ------------------------------------------------------------
  logic [6:0] rx_idx_ff;
  logic [6:0] rx_len_ff;
  logic       rx_fin_ff;
  wire rx_take = (state_ff == rpb_pkg::ST_RX_LISTEN) && i_air_rx_valid &&
                 !rx_fin_ff;
  wire rx_last = rx_take && ((rx_idx_ff == 7'h00) ?
                 (i_air_rx_data[6:0] == 7'h00) : (rx_idx_ff == rx_len_ff));
  wire rx_fcs_hi = fcs_on && (rx_idx_ff != 7'h00) &&
                   (rx_idx_ff == rx_len_ff);
  wire rx_fcs_lo = fcs_on && (rx_idx_ff != 7'h00) &&
                   (rx_idx_ff == rx_len_ff - 7'h01);
  wire [6:0] rx_wr_addr = rx_fin_ff ? rx_len_ff : rx_idx_ff;
  wire [7:0] rx_wr_data = rx_fin_ff ? {crc == 16'h0000, i_sqi[6:0]} :
                          rx_fcs_lo ? i_rssi : i_air_rx_data;
  wire rx_wr_en = (rx_mode != rpb_pkg::RXM_DROP) &&
                  (rx_wr_addr < 7'(rpb_pkg::STORE_DEPTH)) &&
                  ((rx_take && !rx_fcs_hi) ||
                   (rx_fin_ff && fcs_on));
  wire crc_clear = ((state_ff != rpb_pkg::ST_TX_SEND) &&
                    (state_ff != rpb_pkg::ST_RX_LISTEN)) ||
                   (rx_take && (rx_idx_ff == 7'h00));
  wire crc_en = tx_crc_en || (rx_take && (rx_idx_ff != 7'h00));
  wire [7:0] crc_in = (state_ff == rpb_pkg::ST_TX_SEND) ? tx_byte
                                                        : i_air_rx_data;
  rpb_crc16 u_crc (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (crc_clear),
    .i_en       (crc_en),
    .i_data     (crc_in),
    .o_crc      (crc)
  );
  always_ff @(posedge i_core_clk)
  begin
    if (rx_wr_en) rxs_mem[rx_wr_addr[4:0]] <= rx_wr_data;
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_idx_ff <= 7'h00;
      rx_len_ff <= 7'h00;
      rx_fin_ff <= 1'b0;
      crc_ok_ff <= 1'b0;
    end
    else
    begin
      rx_fin_ff <= rx_last;
      if (rx_take && (rx_idx_ff == 7'h00)) rx_len_ff <= i_air_rx_data[6:0];
      if (rx_last || (state_ff != rpb_pkg::ST_RX_LISTEN))
        rx_idx_ff <= 7'h00;
      else if (rx_take)
        rx_idx_ff <= rx_idx_ff + 7'h01;
      if (rx_fin_ff) crc_ok_ff <= (crc == 16'h0000) || !fcs_on;
    end
  end
  // ------------------------------------------------------------
  // radio controller
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    load      = 1'b0;
    load_val  = 11'h000;
    case (state_ff)
      rpb_pkg::ST_IDLE:
        if (i_transmit_command)
        begin
          nxt_state = rpb_pkg::ST_TX_WAIT;
          load      = 1'b1;
          load_val  = tx_wait_us;
        end
        else if (i_receive_command)
        begin
          nxt_state = rpb_pkg::ST_RX_WAIT;
          load      = 1'b1;
          load_val  = rx_wait_us;
        end
      rpb_pkg::ST_TX_WAIT:
        if (cnt_zero && skip_settle)
          nxt_state = rpb_pkg::ST_TX_SEND;
        else if (cnt_zero)
        begin
          nxt_state = rpb_pkg::ST_TX_SETTLE;
          load      = 1'b1;
          load_val  = 11'(rpb_pkg::SETTLE_US);
        end
      rpb_pkg::ST_TX_SETTLE:
        if (cnt_zero) nxt_state = rpb_pkg::ST_TX_SEND;
      rpb_pkg::ST_TX_SEND:
        if (push_last) nxt_state = rpb_pkg::ST_TX_DRAIN;
      rpb_pkg::ST_TX_DRAIN:
        if (drained && send_listen)
        begin
          nxt_state = rpb_pkg::ST_RX_WAIT;
          load      = 1'b1;
          load_val  = rx_wait_us;
        end
        else if (drained && ((tx_mode == rpb_pkg::TXM_RAMP) ||
                             (tx_mode == rpb_pkg::TXM_HOLD)))
        begin
          nxt_state = rpb_pkg::ST_TX_WAIT;
          load      = 1'b1;
          load_val  = tx_wait_us;
        end
        else if (drained)
          nxt_state = rpb_pkg::ST_IDLE;
      rpb_pkg::ST_RX_WAIT:
        if (cnt_zero) nxt_state = rpb_pkg::ST_RX_LISTEN;
      rpb_pkg::ST_RX_LISTEN:
        if (rx_fin_ff && listen_send)
        begin
          nxt_state = rpb_pkg::ST_TX_WAIT;
          load      = 1'b1;
          load_val  = tx_wait_us;
        end
        else if (rx_fin_ff && (rx_mode != rpb_pkg::RXM_CONT) &&
                 (rx_mode != rpb_pkg::RXM_DROP))
          nxt_state = rpb_pkg::ST_IDLE;
      default:
        nxt_state = rpb_pkg::ST_IDLE;
    endcase
    if (i_stop_command) nxt_state = rpb_pkg::ST_IDLE;
  end
  wire tx_active = (nxt_state == rpb_pkg::ST_TX_SETTLE) ||
                   (nxt_state == rpb_pkg::ST_TX_SEND) ||
                   (nxt_state == rpb_pkg::ST_TX_DRAIN);
  wire pa_hold = (nxt_state == rpb_pkg::ST_TX_WAIT) &&
                 (((state_ff == rpb_pkg::ST_TX_DRAIN) &&
                   (tx_mode == rpb_pkg::TXM_HOLD)) ||
                  ((state_ff == rpb_pkg::ST_TX_WAIT) && o_pa_on));
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff           <= rpb_pkg::ST_IDLE;
      o_pa_on            <= 1'b0;
      o_sfd_search       <= 1'b0;
      o_radio_idle_state <= 1'b1;
    end
    else
    begin
      state_ff           <= nxt_state;
      o_pa_on            <= tx_active || pa_hold;
      o_sfd_search       <= (nxt_state == rpb_pkg::ST_RX_LISTEN);
      o_radio_idle_state <= (nxt_state == rpb_pkg::ST_IDLE);
    end
  end
  // ------------------------------------------------------------
  // status, flags and register read
  // ------------------------------------------------------------
  logic [7:0] rd_mux;
  wire [7:0] status = {3'(state_ff), 3'h0, crc_ok_ff, o_frame_rcvd};
  wire frx_clr = wr_status && i_reg_wdata[rpb_pkg::BIT_FRX];
  always_comb
  begin
    if (i_reg_addr == rpb_pkg::ADDR_BUFCFG)      rd_mux = bufcfg_ff;
    else if (i_reg_addr == rpb_pkg::ADDR_PKTCFG) rd_mux = pktcfg_ff;
    else if (i_reg_addr == rpb_pkg::ADDR_RXDLY)  rd_mux = rxdly_ff;
    else if (i_reg_addr == rpb_pkg::ADDR_TXDLY)  rd_mux = txdly_ff;
    else if (i_reg_addr == rpb_pkg::ADDR_DLYEXT) rd_mux = dlyext_ff;
    else if (i_reg_addr == rpb_pkg::ADDR_STATUS) rd_mux = status;
    else                                         rd_mux = 8'h00;
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reg_rdata    <= 8'h00;
      o_rxs_data     <= 8'h00;
      o_frame_rcvd   <= 1'b0;
      o_addon_enable <= 1'b0;
    end
    else
    begin
      if (i_reg_rd) o_reg_rdata <= rd_mux;
      o_rxs_data     <= rxs_mem[i_rxs_addr];
      o_frame_rcvd   <= rx_fin_ff || (o_frame_rcvd && !frx_clr);
      o_addon_enable <= pktcfg_ff[rpb_pkg::BIT_ADDON];
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire drain_done = (state_ff == rpb_pkg::ST_TX_DRAIN) && drained &&
                    !i_stop_command;
  property p_bypass;
    (state_ff == rpb_pkg::ST_IDLE) && i_transmit_command && macdly_off &&
    !i_stop_command |=> (state_ff == rpb_pkg::ST_TX_WAIT) && cnt_zero;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("mac delay not bypassed");
  property p_once;
    drain_done && !send_listen && (tx_mode == rpb_pkg::TXM_ONCE)
    |=> (state_ff == rpb_pkg::ST_IDLE) ##1 o_radio_idle_state;
  endproperty
  a_once: assert property (p_once)
    else $error("single send did not return to idle");
  property p_ramp;
    drain_done && !send_listen && (tx_mode == rpb_pkg::TXM_RAMP)
    |=> (state_ff == rpb_pkg::ST_TX_WAIT) && !o_pa_on;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp repeat wrong");
  property p_hold;
    drain_done && !send_listen && (tx_mode == rpb_pkg::TXM_HOLD)
    |=> (state_ff == rpb_pkg::ST_TX_WAIT) && o_pa_on;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold repeat dropped amplifier");
  property p_turn_rx;
    drain_done && send_listen
    |=> (state_ff == rpb_pkg::ST_RX_WAIT) && (cnt_ff == $past(rx_wait_us));
  endproperty
  a_turn_rx: assert property (p_turn_rx)
    else $error("no turnaround to receive");
  property p_turn_tx;
    (state_ff == rpb_pkg::ST_RX_LISTEN) && rx_fin_ff && listen_send &&
    !i_stop_command |=> (state_ff == rpb_pkg::ST_TX_WAIT);
  endproperty
  a_turn_tx: assert property (p_turn_tx)
    else $error("no turnaround to transmit");
  property p_first;
    (state_ff == rpb_pkg::ST_RX_LISTEN) && rx_fin_ff && !listen_send &&
    (rx_mode == rpb_pkg::RXM_FIRST) && !i_stop_command
    |=> (state_ff == rpb_pkg::ST_IDLE);
  endproperty
  a_first: assert property (p_first)
    else $error("first frame mode kept listening");
  property p_drop;
    (rx_mode == rpb_pkg::RXM_DROP) |-> !rx_wr_en;
  endproperty
  a_drop: assert property (p_drop)
    else $error("store written in drop mode");
  property p_skip;
    (state_ff == rpb_pkg::ST_TX_WAIT) && cnt_zero && skip_settle &&
    !i_stop_command |=> (state_ff == rpb_pkg::ST_TX_SEND);
  endproperty
  a_skip: assert property (p_skip)
    else $error("settling not skipped");
  property p_frx;
    rx_last |=> ##1 o_frame_rcvd;
  endproperty
  a_frx: assert property (p_frx)
    else $error("frame received flag missing");
  property p_fcs_tx;
    push && tx_fcs_hi |-> (tx_in.data == crc[15:8]);
  endproperty
  a_fcs_tx: assert property (p_fcs_tx)
    else $error("appended fcs wrong");
endmodule
`default_nettype wire

// ### logic/rpb_pkg.sv
`default_nettype none
package rpb_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [9:0] ADDR_BUFCFG = 10'h107;
  localparam logic [9:0] ADDR_PKTCFG = 10'h108;
  localparam logic [9:0] ADDR_RXDLY  = 10'h109;
  localparam logic [9:0] ADDR_TXDLY  = 10'h10a;
  localparam logic [9:0] ADDR_DLYEXT = 10'h10b;
  localparam logic [9:0] ADDR_STATUS = 10'h10c;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RST_BUFCFG = 8'h00;
  localparam logic [7:0] RST_PKTCFG = 8'h04;
  localparam logic [7:0] RST_RXDLY  = 8'hc0;
  localparam logic [7:0] RST_TXDLY  = 8'hc0;
  localparam logic [7:0] RST_DLYEXT = 8'h00;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int BIT_MACDLY_OFF  = 7;
  localparam int TXMODE_LO       = 4;
  localparam int BIT_SEND_LISTEN = 3;
  localparam int BIT_LISTEN_SEND = 2;
  localparam int RXMODE_LO       = 0;
  localparam int BIT_ADDON       = 4;
  localparam int BIT_SKIP_SETTLE = 3;
  localparam int BIT_FCS_OFF     = 0;
  localparam int BIT_FRX         = 0;
  localparam int BIT_CRC_OK      = 1;
  // --------------------------------------------------------------
  // modes
  // --------------------------------------------------------------
  localparam logic [1:0] TXM_ONCE  = 2'h0;
  localparam logic [1:0] TXM_RAMP  = 2'h1;
  localparam logic [1:0] TXM_HOLD  = 2'h3;
  localparam logic [1:0] RXM_FIRST = 2'h0;
  localparam logic [1:0] RXM_CONT  = 2'h1;
  localparam logic [1:0] RXM_DROP  = 2'h2;
  // --------------------------------------------------------------
  // timing and sizes
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_US       = 1;
  localparam int TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int EXT_STEP_US   = 4;
  localparam int SETTLE_US     = 8;
  localparam int STORE_DEPTH   = 32;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TX_WAIT, ST_TX_SETTLE, ST_TX_SEND,
    ST_TX_DRAIN, ST_RX_WAIT, ST_RX_LISTEN
  } rpb_state_t;
endpackage
`default_nettype wire

// ### logic/rpb_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rpb_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### logic/rpb_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rpb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  // streams
  rpb_stream_if.snk   s_in,
  rpb_stream_if.src   s_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  wire          full;
  wire          empty;
  wire          push;
  wire          pop;
  assign full  = (wp_ff[AW] != rp_ff[AW]) &&
                 (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty = (wp_ff == rp_ff);
  assign push  = s_in.valid && !full;
  assign pop   = s_out.ready && !empty;
  assign s_in.ready  = !full;
  assign s_out.valid = !empty;
  assign s_out.data  = mem[rp_ff[AW-1:0]];
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
    end
    else
    begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (push) mem[wp_ff[AW-1:0]] <= s_in.data;
  end
endmodule
`default_nettype wire

// ### logic/rpb_crc16.sv
`timescale 1ns/100ps
`default_nettype none
module rpb_crc16 (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // byte input
  input  wire logic        i_clear,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_data,
  // result
  output var  logic [15:0] o_crc
);
  logic [15:0] nxt_crc;
  always_comb
  begin
    nxt_crc = o_crc ^ {8'h00, i_data};
    for (int b = 0; b < 8; b++)
      nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ rpb_pkg::CRC_POLY)
                           : (nxt_crc >> 1);
  end
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)        o_crc <= 16'h0000;
    else if (i_clear) o_crc <= 16'h0000;
    else if (i_en)    o_crc <= nxt_crc;
  end
endmodule
`default_nettype wire

// ### verif/rpb_air_model.sv
`timescale 1ns/100ps
`default_nettype none
module rpb_air_model (
  // air side
  input  wire logic       i_core_clk,
  output var  logic       o_tx_ready,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_data
);
  logic slow = 1'b0;
  logic ph = 1'b0;
  always @(posedge i_core_clk) ph <= ~ph;
  // slow mode stalls every other cycle
  assign o_tx_ready = slow ? ph : 1'b1;
  initial {o_rx_valid, o_rx_data} = 9'h0;
  task automatic send(input logic [7:0] len, input logic [7:0] s);
    {o_rx_valid, o_rx_data} = {1'b1, len};
    for (int k = 1; k <= len; k++)
      @(posedge i_core_clk) #1 o_rx_data = s + 8'(k);
    @(posedge i_core_clk) #1 o_rx_valid = 1'b0;
    // released data shows the inverse
    o_rx_data = ~o_rx_data;
    // cycle after the last byte is refused
    @(posedge i_core_clk) #1;
  endtask
endmodule
`default_nettype wire

// ### verif/rpb_framer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch %0t %h", $time, (a)); end end
module rpb_framer_tb_top;
  logic       i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_txs_wr;
  logic       i_transmit_command, i_receive_command, i_stop_command;
  logic       i_air_tx_ready, i_air_rx_valid, o_air_tx_valid, o_pa_on;
  logic       o_sfd_search, o_radio_idle_state, o_frame_rcvd, o_addon_enable;
  logic [9:0] i_reg_addr;
  logic [4:0] i_txs_addr, i_rxs_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, i_txs_wdata, o_rxs_data;
  logic [7:0] o_air_tx_data, i_air_rx_data, i_rssi, i_sqi;
  logic [7:0] txq[$];
  int         mismatches = 0, total_checks = 0, cyc = 0;
  rpb_framer u_dut (.*);
  rpb_air_model u_air (.i_core_clk, .o_tx_ready(i_air_tx_ready),
    .o_rx_valid(i_air_rx_valid), .o_rx_data(i_air_rx_data));
  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
  begin
    if (o_air_tx_valid && i_air_tx_ready) txq.push_back(o_air_tx_data);
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    {i_reg_addr, i_reg_wdata} = {a, d};
    pulse(i_reg_wr);
  endtask
  task automatic rreg(input logic [9:0] a, input logic [7:0] e);
    i_reg_addr = a;
    pulse(i_reg_rd);
    `CHK(o_reg_rdata, e)
  endtask
  task automatic rstore(input logic [4:0] a, input logic [7:0] e);
    i_rxs_addr = a;
    tick(1);
    `CHK(o_rxs_data, e)
  endtask
  task automatic wt(input bit s);
    for (int n = 0; n < 3000; n++)
      if ((s ? o_sfd_search : o_radio_idle_state) !== 1'b1) tick(1);
  endtask
  task automatic t_regs();
    rreg(rpb_pkg::ADDR_BUFCFG, 8'h00);
    rreg(rpb_pkg::ADDR_PKTCFG, 8'h04);
    rreg(rpb_pkg::ADDR_RXDLY, 8'hc0);
    rreg(10'h1ff, 8'h00);
    wreg(rpb_pkg::ADDR_PKTCFG, 8'h14);
    tick(1);
    `CHK(o_addon_enable, 1'b1)
  endtask
  task automatic t_tx();
    for (int k = 0; k < 4; k++)
    begin
      {i_txs_addr, i_txs_wdata} = {5'(k), k ? 8'ha0 + 8'(k) : 8'h03};
      pulse(i_txs_wr);
    end
    wreg(rpb_pkg::ADDR_PKTCFG, 8'h05);
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h80);
    txq.delete();
    pulse(i_transmit_command);
    tick(2);
    `CHK(o_radio_idle_state, 1'b0)
    wt(0);
    `CHK(txq.size(), 4)
    for (int k = 0; k < 4; k++) `CHK(txq[k], k ? 8'ha0 + 8'(k) : 8'h03)
  endtask
  task automatic t_turn();
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h88);
    u_air.slow = 1'b1;
    txq.delete();
    pulse(i_transmit_command);
    wt(1);
    `CHK(o_sfd_search, 1'b1)
    `CHK(txq.size(), 4)
    u_air.slow = 1'b0;
    pulse(i_stop_command);
  endtask
  task automatic t_rx_first();
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h80);
    wt(0);
    pulse(i_receive_command);
    wt(1);
    u_air.send(8'h03, 8'h10);
    tick(2);
    `CHK(o_frame_rcvd, 1'b1)
    wreg(rpb_pkg::ADDR_STATUS, 8'h01);
    tick(1);
    `CHK(o_frame_rcvd, 1'b0)
    `CHK(o_radio_idle_state, 1'b1)
    rstore(5'h00, 8'h03);
    rstore(5'h03, 8'h13);
  endtask
  task automatic t_rx_drop();
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h82);
    pulse(i_receive_command);
    wt(1);
    u_air.send(8'h03, 8'h50);
    tick(2);
    rstore(5'h01, 8'h11);
    `CHK(o_sfd_search, 1'b1)
    pulse(i_stop_command);
  endtask
  task automatic t_rx_cont();
    wreg(rpb_pkg::ADDR_PKTCFG, 8'h04);
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h81);
    wt(0);
    pulse(i_receive_command);
    wt(1);
    u_air.send(8'h04, 8'h20);
    u_air.send(8'h04, 8'h30);
    tick(2);
    `CHK(o_sfd_search, 1'b1)
    rstore(5'h01, 8'h31);
    rstore(5'h03, 8'h5a);
    i_rxs_addr = 5'h04;
    tick(1);
    `CHK(o_rxs_data[6:0], 7'h33)
    pulse(i_stop_command);
  endtask
  task automatic t_delay();
    wreg(rpb_pkg::ADDR_RXDLY, 8'h02);
    wreg(rpb_pkg::ADDR_DLYEXT, 8'h01);
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h00);
    pulse(i_receive_command);
    tick(1150);
    `CHK(o_sfd_search, 1'b0)
    tick(100);
    `CHK(o_sfd_search, 1'b1)
    pulse(i_stop_command);
  endtask
  task automatic t_repeat();
    int          off;
    logic [15:0] c;
    c = 16'h00a1;
    for (int b = 0; b < 8; b++)
      c = c[0] ? ((c >> 1) ^ rpb_pkg::CRC_POLY) : (c >> 1);
    wreg(rpb_pkg::ADDR_PKTCFG, 8'h0c);
    wreg(rpb_pkg::ADDR_BUFCFG, 8'hb0);
    txq.delete();
    pulse(i_transmit_command);
    off = 0;
    repeat (40)
    begin
      if (!o_pa_on) off++;
      tick(1);
    end
    `CHK(off, 0)
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h90);
    off = 0;
    repeat (40)
    begin
      if (!o_pa_on) off++;
      tick(1);
    end
    `CHK(off > 0, 1'b1)
    wreg(rpb_pkg::ADDR_BUFCFG, 8'h80);
    wt(0);
    `CHK(o_pa_on, 1'b0)
    `CHK(txq[1], 8'ha1)
    `CHK(txq[2], c[7:0])
    `CHK(txq[3], c[15:8])
    `CHK(txq[4], 8'h03)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {i_rst, i_reg_wr, i_reg_rd, i_txs_wr, i_transmit_command} = 5'h10;
    {i_receive_command, i_stop_command, i_reg_addr, i_reg_wdata} = 20'h0;
    {i_txs_addr, i_txs_wdata, i_rxs_addr, i_rssi, i_sqi} = 34'h0_5a33;
    tick(5);
    i_rst = 1'b0;
    t_regs();
    t_tx();
    t_turn();
    t_rx_first();
    t_rx_drop();
    t_rx_cont();
    t_delay();
    t_repeat();
    conclude();
  end
endmodule
`default_nettype wire
